// ### rtl/dmr_pkg.sv
// dmr_pkg: register offsets, field positions, codes and carriers of the drive
// register map. Assumes word addressing as seen by the serial framer.
package dmr_pkg;
    // command group (read and write)
    localparam logic [15:0] CMD_RSVD0_ADDR  = 16'h2400;
    localparam logic [15:0] OPCMD_ADDR      = 16'h2401;
    localparam logic [15:0] FREQ_SET_ADDR   = 16'h2402;
    localparam logic [15:0] CMD_RSVD3_ADDR  = 16'h2403;
    // monitor group (read only)
    localparam logic [15:0] MON_RSVD0_ADDR  = 16'h2420;
    localparam logic [15:0] OPSTATE_ADDR    = 16'h2421;
    localparam logic [15:0] FREQ_ECHO_ADDR  = 16'h2422;
    localparam logic [15:0] OUT_FREQ_ADDR   = 16'h2423;
    localparam logic [15:0] OUT_CUR_ADDR    = 16'h2424;
    localparam logic [15:0] OUT_VOLT_ADDR   = 16'h2425;
    localparam logic [15:0] DC_BUS_ADDR     = 16'h2426;
    localparam logic [15:0] ALARM_ADDR      = 16'h2427;
    localparam logic [15:0] FAULT_ADDR      = 16'h2428;
    localparam logic [15:0] IO_STATE_ADDR   = 16'h2429;
    localparam logic [15:0] AIN_ONE_ADDR    = 16'h242A;
    localparam logic [15:0] AIN_TWO_ADDR    = 16'h242B;
    localparam logic [15:0] MON_RSVDC_ADDR  = 16'h242C;
    localparam logic [15:0] AOUT_ONE_ADDR   = 16'h242D;
    localparam logic [15:0] AOUT_TWO_ADDR   = 16'h242E;
    // operation command word fields
    localparam int          OPC_RUN_BIT     = 0;
    localparam int          OPC_DIR_BIT     = 1;
    localparam int          OPC_EXTF_BIT    = 2;
    localparam int          OPC_FRST_BIT    = 3;
    localparam int          OPC_VT_LSB      = 8;
    localparam int          VT_COUNT        = 7;
    localparam logic [15:0] OPC_WR_MASK     = 16'h7F0F;
    localparam logic [15:0] OPC_RESET       = 16'h0000;
    localparam logic [15:0] FREQ_RESET      = 16'h0000;
    // operation state word fields
    localparam int          ST_RUN_BIT      = 0;
    localparam int          ST_REV_BIT      = 1;
    localparam int          ST_ZHOLD_BIT    = 2;
    localparam int          ST_FAULT_BIT    = 3;
    localparam int          ST_ALARM_BIT    = 4;
    localparam int          ST_AGREE_BIT    = 5;
    localparam int          ST_READY_BIT    = 6;
    localparam int          ST_FSRC_BIT     = 7;
    localparam int          ST_REMOTE_BIT   = 8;
    // io state word fields
    localparam int          IO_DI_LSB       = 0;
    localparam int          IO_RELAY1_BIT   = 12;
    localparam int          IO_RELAY2_BIT   = 13;
    localparam int          IO_PULSE_BIT    = 14;
    // alarm and fault codes
    localparam logic [15:0] ALM_NONE        = 16'h0000;
    localparam logic [15:0] ALM_OPT_EXT     = 16'h0001;
    localparam logic [15:0] ALM_EXT_FIRST   = 16'h0002;
    localparam logic [15:0] ALM_COMM_FAIL   = 16'h0024;
    localparam logic [15:0] ALM_AIN_LOSS    = 16'h0026;
    localparam logic [15:0] ALM_DC_RELAY    = 16'h0030;
    localparam logic [15:0] FLT_NONE        = 16'h0000;
    localparam logic [15:0] FLT_PHASE_LOSS  = 16'h002E;
    // analog scaling: inputs arrive in thousandths of full span
    localparam logic [15:0] SCALE_FULL      = 16'h03E8;
    localparam logic [15:0] AIN_LIVE_ZERO   = 16'h00C8;
    // exception answers
    localparam logic [7:0]  FUNC_EXC_FLAG   = 8'h80;
    localparam logic [7:0]  EXC_BAD_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_READ_ONLY   = 8'h03;

    typedef enum logic [1:0] {
        ACC_OK        = 2'b00,
        ACC_BAD_ADDR  = 2'b01,
        ACC_READ_ONLY = 2'b10
    } dmr_access_e;

    // drive condition levels shown in the operation state word
    typedef struct packed {
        logic running;
        logic reversing;
        logic zero_hold;
        logic speed_agree;
        logic ready;
        logic freq_src;
        logic run_remote;
    } dmr_drive_s;

    // raw electrical quantities, already in their register units
    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] out_cur;
        logic [15:0] out_volt;
        logic [15:0] dc_bus;
    } dmr_meas_s;

    // alarm sources
    typedef struct packed {
        logic       option_card_ext_fault;
        logic [7:0] external_fault;
        logic       comm_fail;
        logic       analog_input_loss;
        logic       dc_relay_slow_start_fault;
    } dmr_alarm_s;
endpackage

// ### rtl/dmr_regmap.sv
// dmr_regmap: command and monitor register bank of the drive, one word per
// request. Assumes a serial framer that checks framing and CRC/LRC, then
// hands over one decoded word access and sends back the answer it gets.
// Monitor words show inputs of the taking cycle; the setpoint echo shows the stored setpoint, the fault word and fault bit the latched cause.
// The answer comes a clock later; its words stand until the next request, its valid lasts one cycle.
// Reserved words read zero; command-group ones take writes silently, monitor-group ones refuse them.
`timescale 1ns/1ps

module dmr_regmap
    import dmr_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               arst_n,
    // decoded word access from the serial framer
    input  wire logic               req_valid,
    input  wire logic               req_write,
    input  wire logic [7:0]         req_func,
    input  wire logic [15:0]        req_addr,
    input  wire logic [15:0]        req_wdata,
    output logic                    rsp_valid,
    output logic [7:0]              rsp_func,
    output logic                    rsp_exc,
    output logic [7:0]              rsp_exc_code,
    output logic [15:0]             rsp_rdata,
    // drive state feeding the monitor words
    input  wire dmr_drive_s         drive,
    input  wire dmr_meas_s          meas,
    input  wire dmr_alarm_s         alarm,
    input  wire logic               fault_valid,
    input  wire logic [15:0]        fault_cause,
    input  wire logic               input_phase_loss,
    input  wire logic [6:0]         di_state,
    input  wire logic [1:0]         relay_state,
    input  wire logic               pulse_output,
    input  wire logic               ain_one_current,
    input  wire logic               ain_two_current,
    input  wire logic [15:0]        ain_one_raw,
    input  wire logic [15:0]        ain_two_raw,
    input  wire logic signed [15:0] aout_one_raw,
    input  wire logic signed [15:0] aout_two_raw,
    // commands applied to the drive
    output logic                    run_cmd,
    output logic                    reverse_cmd,
    output logic                    option_card_ext_fault,
    output logic                    fault_reset_pulse,
    output logic [6:0]              virtual_terminal,
    output logic [15:0]             freq_setpoint
);

    // whole bank state
    typedef struct packed {
        // command words
        logic [15:0] opcmd;
        logic [15:0] freq;
        // fault latch
        logic [15:0] fault_code;
        logic        frst_pulse;
        // last answer
        logic        rsp_valid;
        logic [7:0]  rsp_func;
        logic        rsp_exc;
        logic [7:0]  rsp_exc_code;
        logic [15:0] rsp_rdata;
    } dmr_state_s;

    // idle: stopped, no fault
    localparam dmr_state_s STATE_RESET = '{
        opcmd:        OPC_RESET,
        freq:         FREQ_RESET,
        fault_code:   FLT_NONE,
        frst_pulse:   1'b0,
        rsp_valid:    1'b0,
        rsp_func:     8'h00,
        rsp_exc:      1'b0,
        rsp_exc_code: 8'h00,
        rsp_rdata:    16'h0000
    };

    // reset release
    logic        rst_meta_q;
    logic        rst_n_q;

    // state
    dmr_state_s  st_q;
    dmr_state_s  st_d;

    // access kind
    dmr_access_e acc;

    // word views
    logic [15:0] alarm_code;
    logic [15:0] op_state;
    logic [15:0] io_state;
    logic [15:0] ain_one_val;
    logic [15:0] ain_two_val;
    logic [15:0] aout_one_val;
    logic [15:0] aout_two_val;
    logic [15:0] rd_word;

    // command and fault terms
    logic [15:0] opcmd_wr;
    logic        frst_rise;
    logic        fault_event;
    logic [15:0] fault_event_code;

    // reset release through two flops
    // async clear, clocked release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // clamp a thousandths-of-span value to full scale
    function automatic logic [15:0] clamp_full(input logic [15:0] v);
        clamp_full = (v > SCALE_FULL) ? SCALE_FULL : v;
    endfunction

    // clamp a signed value to plus or minus full scale
    // (two's complement words)
    function automatic logic [15:0] clamp_signed(input logic signed [15:0] v);
        logic signed [15:0] hi;
        hi = $signed(SCALE_FULL);
        if (v > hi) begin
            clamp_signed = SCALE_FULL;
        end else if (v < -hi) begin
            clamp_signed = 16'(-hi);
        end else begin
            clamp_signed = 16'(v);
        end
    endfunction

    // live-zero span: 200..1000 thousandths of 20mA becomes 0..1000
    // 4mA is 200; 800 left scale by 1.25
    function automatic logic [15:0] live_zero(input logic [15:0] v);
        logic [17:0] above;
        above = 18'(clamp_full(v)) - 18'(AIN_LIVE_ZERO);
        if (clamp_full(v) <= AIN_LIVE_ZERO) begin
            live_zero = 16'h0000;
        end else begin
            live_zero = 16'(above + (above >> 2));
        end
    endfunction

    // analog words in register units
    // first input maps alike in both modes
    always_comb begin
        ain_one_val  = clamp_full(ain_one_raw);
        ain_two_val  = ain_two_current ? live_zero(ain_two_raw)
                                       : clamp_full(ain_two_raw);

        // outputs keep their sign
        aout_one_val = clamp_signed(aout_one_raw);
        aout_two_val = clamp_signed(aout_two_raw);
    end

    // alarm code: option fault first, then external faults, then the rest
    always_comb begin
        alarm_code = ALM_NONE;
        if (alarm.option_card_ext_fault || st_q.opcmd[OPC_EXTF_BIT]) begin
            alarm_code = ALM_OPT_EXT;
        end else if (alarm.external_fault != 8'h00) begin
            // lowest fault number wins
            for (int i = 7; i >= 0; i--) begin
                if (alarm.external_fault[i]) begin
                    alarm_code = ALM_EXT_FIRST + 16'(i);
                end
            end
        end else if (alarm.comm_fail) begin
            alarm_code = ALM_COMM_FAIL;
        end else if (alarm.analog_input_loss) begin
            alarm_code = ALM_AIN_LOSS;
        end else if (alarm.dc_relay_slow_start_fault) begin
            alarm_code = ALM_DC_RELAY;
        end
    end

    // operation state and io words, reserved bits held at zero
    always_comb begin
        op_state                = 16'h0000;
        op_state[ST_RUN_BIT]    = drive.running;
        op_state[ST_REV_BIT]    = drive.reversing;
        op_state[ST_ZHOLD_BIT]  = drive.zero_hold;
        // fault, alarm bits from the codes
        op_state[ST_FAULT_BIT]  = (st_q.fault_code != FLT_NONE);
        op_state[ST_ALARM_BIT]  = (alarm_code != ALM_NONE);
        op_state[ST_AGREE_BIT]  = drive.speed_agree;
        op_state[ST_READY_BIT]  = drive.ready;
        op_state[ST_FSRC_BIT]   = drive.freq_src;
        op_state[ST_REMOTE_BIT] = drive.run_remote;

        // io word
        io_state                = 16'h0000;
        io_state[IO_DI_LSB +: 7]  = di_state;
        io_state[IO_RELAY1_BIT] = relay_state[0];
        io_state[IO_RELAY2_BIT] = relay_state[1];
        io_state[IO_PULSE_BIT]  = pulse_output;
    end

    // address decode and read multiplexer
    always_comb begin
        acc     = ACC_OK;
        rd_word = 16'h0000;
        case (req_addr)
            // command group
            CMD_RSVD0_ADDR,
            CMD_RSVD3_ADDR: rd_word = 16'h0000;
            OPCMD_ADDR:     rd_word = st_q.opcmd;
            FREQ_SET_ADDR:  rd_word = st_q.freq;
            // monitor group
            MON_RSVD0_ADDR,
            MON_RSVDC_ADDR: rd_word = 16'h0000;
            OPSTATE_ADDR:   rd_word = op_state;
            FREQ_ECHO_ADDR: rd_word = st_q.freq;
            OUT_FREQ_ADDR:  rd_word = meas.out_freq;
            OUT_CUR_ADDR:   rd_word = meas.out_cur;
            OUT_VOLT_ADDR:  rd_word = meas.out_volt;
            DC_BUS_ADDR:    rd_word = meas.dc_bus;
            ALARM_ADDR:     rd_word = alarm_code;
            FAULT_ADDR:     rd_word = st_q.fault_code;
            IO_STATE_ADDR:  rd_word = io_state;
            AIN_ONE_ADDR:   rd_word = ain_one_val;
            AIN_TWO_ADDR:   rd_word = ain_two_val;
            AOUT_ONE_ADDR:  rd_word = aout_one_val;
            AOUT_TWO_ADDR:  rd_word = aout_two_val;
            // unmapped
            default:        acc     = ACC_BAD_ADDR;
        endcase

        // monitor words refuse writes and keep their values
        if (req_write && acc == ACC_OK &&
            req_addr >= MON_RSVD0_ADDR && req_addr <= AOUT_TWO_ADDR) begin
            acc = ACC_READ_ONLY;
        end
    end

    // fault events: a new cause wins over a fault reset in the same cycle
    always_comb begin
        opcmd_wr         = req_wdata & OPC_WR_MASK;

        // bit 3 rising only
        frst_rise        = req_valid && req_write && acc == ACC_OK &&
                           req_addr == OPCMD_ADDR &&
                           opcmd_wr[OPC_FRST_BIT] &&
                           !st_q.opcmd[OPC_FRST_BIT];

        // phase loss outranks a cause
        fault_event      = (fault_valid && fault_cause != FLT_NONE) ||
                           input_phase_loss;
        fault_event_code = input_phase_loss ? FLT_PHASE_LOSS
                                            : fault_cause;
    end

    // next state
    always_comb begin
        st_d            = st_q;
        // answer and pulse last one cycle
        st_d.rsp_valid  = 1'b0;
        st_d.frst_pulse = frst_rise;

        // answer this edge's request
        if (req_valid) begin
            st_d.rsp_valid    = 1'b1;
            st_d.rsp_exc      = (acc != ACC_OK);
            st_d.rsp_func     = (acc != ACC_OK) ? (req_func | FUNC_EXC_FLAG)
                                                : req_func;
            st_d.rsp_exc_code = (acc == ACC_BAD_ADDR)  ? EXC_BAD_ADDR :
                                (acc == ACC_READ_ONLY) ? EXC_READ_ONLY :
                                8'h00;
            st_d.rsp_rdata    = req_write ? req_wdata : rd_word;
            // refused: no data
            if (acc != ACC_OK) begin
                st_d.rsp_rdata = 16'h0000;
            end

            // accepted writes
            if (req_write && acc == ACC_OK) begin
                if (req_addr == OPCMD_ADDR) begin
                    st_d.opcmd = opcmd_wr;
                end
                if (req_addr == FREQ_SET_ADDR) begin
                    st_d.freq = req_wdata;
                end
            end
        end

        // reset clears; an event wins
        if (frst_rise) begin
            st_d.fault_code = FLT_NONE;
        end
        if (fault_event && (st_q.fault_code == FLT_NONE || frst_rise)) begin
            st_d.fault_code = fault_event_code;
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign rsp_valid             = st_q.rsp_valid;
    assign rsp_func              = st_q.rsp_func;
    assign rsp_exc               = st_q.rsp_exc;
    assign rsp_exc_code          = st_q.rsp_exc_code;
    assign rsp_rdata             = st_q.rsp_rdata;

    // drive commands
    assign run_cmd               = st_q.opcmd[OPC_RUN_BIT];
    assign reverse_cmd           = st_q.opcmd[OPC_DIR_BIT];
    assign option_card_ext_fault = st_q.opcmd[OPC_EXTF_BIT];
    assign fault_reset_pulse     = st_q.frst_pulse;
    assign virtual_terminal      = st_q.opcmd[OPC_VT_LSB +: VT_COUNT];
    assign freq_setpoint         = st_q.freq;

endmodule // dmr_regmap

// ### tb/dmr_regmap_sva.sv
// dmr_regmap_sva: answer timing and command-word checks on the register bank.
// Assumes the top-level ports of dmr_regmap only; attached by bind below.
`timescale 1ns/1ps

module dmr_regmap_sva
    import dmr_pkg::*;
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [7:0]  req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_func,
    input wire logic        rsp_exc,
    input wire logic [7:0]  rsp_exc_code,
    input wire logic [15:0] rsp_rdata,
    input wire logic        run_cmd,
    input wire logic        reverse_cmd,
    input wire logic        fault_reset_pulse,
    input wire logic [6:0]  virtual_terminal,
    input wire logic [15:0] freq_setpoint
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // address decode and write strobes seen at the request
    logic in_cmd;
    logic in_mon;
    logic opc_wr;
    logic set_wr;
    assign in_cmd = req_addr >= CMD_RSVD0_ADDR && req_addr <= CMD_RSVD3_ADDR;
    assign in_mon = req_addr >= MON_RSVD0_ADDR && req_addr <= AOUT_TWO_ADDR;
    assign opc_wr = req_valid && req_write && req_addr == OPCMD_ADDR;
    assign set_wr = req_valid && req_write && req_addr == FREQ_SET_ADDR;
    logic frst_wr;
    assign frst_wr = opc_wr && req_wdata[3];

    sequence s_opcmd_write;
        opc_wr;
    endsequence
    sequence s_setpoint_write;
        set_wr;
    endsequence

    a_answer_follows: assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    a_no_stray: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    a_unmapped_exc: assert property (req_valid && !in_cmd && !in_mon |=> rsp_exc
        && rsp_exc_code == EXC_BAD_ADDR && rsp_func == ($past(req_func) | FUNC_EXC_FLAG)
        && rsp_rdata == 16'h0000)
        else $error("unmapped access not refused");
    a_monitor_refuse: assert property (req_valid && req_write && in_mon |=> rsp_exc
        && rsp_exc_code == EXC_READ_ONLY && $stable(freq_setpoint) && $stable(run_cmd))
        else $error("monitor write not refused");
    a_cmd_accept: assert property (req_valid && in_cmd |=> !rsp_exc
        && rsp_func == $past(req_func))
        else $error("command group access refused");
    a_setpoint_load: assert property (s_setpoint_write |=>
        freq_setpoint == $past(req_wdata) && rsp_rdata == $past(req_wdata))
        else $error("setpoint not loaded");
    a_setpoint_hold: assert property (!set_wr |=> $stable(freq_setpoint))
        else $error("setpoint changed without write");
    a_run_follow: assert property (s_opcmd_write |=> run_cmd == $past(req_wdata[0])
        && reverse_cmd == $past(req_wdata[1]))
        else $error("run or direction not applied");
    a_terminal_follow: assert property (s_opcmd_write |=>
        virtual_terminal == $past(req_wdata[14:8]))
        else $error("virtual terminals not applied");
    a_reset_pulse: assert property (fault_reset_pulse |->
        $past(frst_wr) ##1 !fault_reset_pulse)
        else $error("fault reset pulse malformed");
endmodule // dmr_regmap_sva

bind dmr_regmap dmr_regmap_sva u_sva (.clock, .arst_n, .req_valid, .req_write, .req_func,
    .req_addr, .req_wdata, .rsp_valid, .rsp_func, .rsp_exc, .rsp_exc_code, .rsp_rdata,
    .run_cmd, .reverse_cmd, .fault_reset_pulse, .virtual_terminal, .freq_setpoint);

// ### tb/dmr_master.sv
// dmr_master: serial master model handing one decoded word access per call.
// Assumes the bank registers its answer at the taking edge, ready by the next falling edge.
`timescale 1ns/1ps

module dmr_master
    import dmr_pkg::*;
(
    input  wire logic   clock,
    output logic        req_valid,
    output logic        req_write,
    output logic [7:0]  req_func,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata
);
    // idle lines carry a pattern, never a stale word
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_func  = 8'hFF;
        req_addr  = 16'hFFFF;
        req_wdata = 16'h5A5A;
    end

    // drive after a falling edge, hold across the taking edge, then release
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wd);
        @(negedge clock);
        req_valid = 1'b1;
        req_write = wr;
        req_func  = wr ? 8'h06 : 8'h03;
        req_addr  = addr;
        req_wdata = wd;
        @(negedge clock);
        req_valid = 1'b0;
        req_write = ~wr;
        req_func  = ~req_func;
        req_addr  = ~addr;
        req_wdata = ~wd;
    endtask
endmodule // dmr_master

// ### tb/tb_dmr_regmap.sv
// tb_dmr_regmap: directed scenarios for the drive register bank.
// Assumes dmr_master drives requests; drive inputs change at falling edges.
`timescale 1ns/1ps

module tb_dmr_regmap;
    import dmr_pkg::*;
    logic clock, arst_n, fault_valid, input_phase_loss, pulse_output;
    logic ain_one_current, ain_two_current;
    logic req_valid, req_write, rsp_valid, rsp_exc, run_cmd, reverse_cmd;
    logic option_card_ext_fault, fault_reset_pulse;
    logic [7:0] req_func, rsp_func, rsp_exc_code;
    logic [15:0] req_addr, req_wdata, rsp_rdata, freq_setpoint, fault_cause;
    logic [15:0] ain_one_raw, ain_two_raw;
    logic signed [15:0] aout_one_raw, aout_two_raw;
    logic [6:0] di_state, virtual_terminal;
    logic [1:0] relay_state;
    dmr_drive_s drive;
    dmr_meas_s meas;
    dmr_alarm_s alarm;
    int failures, num_checks;
    wire logic [15:0] cmd_view = {5'h00, virtual_terminal, fault_reset_pulse,
                                  option_card_ext_fault, reverse_cmd, run_cmd};

    dmr_master u_m (.clock, .req_valid, .req_write, .req_func, .req_addr, .req_wdata);
    dmr_regmap dut (.clock, .arst_n, .req_valid, .req_write, .req_func, .req_addr,
        .req_wdata, .rsp_valid, .rsp_func, .rsp_exc, .rsp_exc_code, .rsp_rdata, .drive,
        .meas, .alarm, .fault_valid, .fault_cause, .input_phase_loss, .di_state,
        .relay_state, .pulse_output, .ain_one_current, .ain_two_current, .ain_one_raw,
        .ain_two_raw, .aout_one_raw, .aout_two_raw, .run_cmd, .reverse_cmd,
        .option_card_ext_fault, .fault_reset_pulse, .virtual_terminal, .freq_setpoint);

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
        u_m.xfer(1'b0, a, 16'h0000);
        check(n, rsp_rdata, e);
    endtask
    task automatic test_done();
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic t_command();
        u_m.xfer(1'b1, OPCMD_ADDR, 16'hFFFF);
        check("command outputs", cmd_view, 16'h07FF);
        rd(OPCMD_ADDR, 16'h7F0F, "command word");
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0002);
        check("reverse only", cmd_view, 16'h0002);
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0000);
    endtask
    task automatic t_setpoint_reserved();
        u_m.xfer(1'b1, FREQ_SET_ADDR, 16'h1770);
        check("setpoint", freq_setpoint, 16'h1770);
        rd(FREQ_ECHO_ADDR, 16'h1770, "setpoint echo");
        u_m.xfer(1'b1, CMD_RSVD0_ADDR, 16'hFFFF);
        check("reserved write", {rsp_func, rsp_exc_code}, 16'h0600);
        rd(CMD_RSVD0_ADDR, 16'h0000, "reserved word");
        u_m.xfer(1'b1, CMD_RSVD3_ADDR, 16'hFFFF);
        rd(CMD_RSVD3_ADDR, 16'h0000, "reserved word");
        rd(MON_RSVD0_ADDR, 16'h0000, "reserved monitor");
        rd(MON_RSVDC_ADDR, 16'h0000, "reserved monitor");
    endtask
    task automatic t_refuse();
        u_m.xfer(1'b1, OUT_FREQ_ADDR, 16'h0000);
        check("read only refusal", {rsp_func, rsp_exc_code}, 16'h8603);
        rd(OUT_FREQ_ADDR, 16'h1234, "output frequency");
        rd(OUT_CUR_ADDR, 16'h0056, "output current");
        rd(OUT_VOLT_ADDR, 16'h0DC0, "output voltage");
        rd(DC_BUS_ADDR, 16'h1518, "dc bus");
        u_m.xfer(1'b0, 16'h2404, 16'h0000);
        check("unmapped refusal", {rsp_func, rsp_exc_code}, 16'h8302);
        check("unmapped data", rsp_rdata, 16'h0000);
    endtask
    task automatic t_status_alarm();
        drive = '1;
        rd(OPSTATE_ADDR, 16'h01E7, "state word");
        drive = '0;
        for (int i = 0; i < 8; i++) begin
            alarm = '0;
            alarm.external_fault = 8'h01 << i;
            rd(ALARM_ADDR, 16'(i + 2), "external fault code");
        end
        alarm.option_card_ext_fault = 1'b1;
        rd(ALARM_ADDR, 16'h0001, "option fault code");
        alarm = '0;
        alarm.comm_fail = 1'b1;
        rd(ALARM_ADDR, 16'h0024, "comm fail code");
        rd(OPSTATE_ADDR, 16'h0010, "alarm state");
        alarm = '0;
        alarm.analog_input_loss = 1'b1;
        rd(ALARM_ADDR, 16'h0026, "analog loss code");
        alarm = '0;
        alarm.dc_relay_slow_start_fault = 1'b1;
        rd(ALARM_ADDR, 16'h0030, "dc relay code");
        alarm = '0;
        rd(ALARM_ADDR, 16'h0000, "no alarm");
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0004);
        rd(ALARM_ADDR, 16'h0001, "commanded option fault");
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0000);
    endtask
    task automatic t_fault();
        input_phase_loss = 1'b1;
        @(negedge clock);
        input_phase_loss = 1'b0;
        rd(FAULT_ADDR, 16'h002E, "phase loss code");
        rd(OPSTATE_ADDR, 16'h0008, "fault state");
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0008);
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0000);
        rd(FAULT_ADDR, 16'h0000, "fault cleared");
        fault_valid = 1'b1;
        fault_cause = 16'h0011;
        @(negedge clock);
        fault_valid = 1'b0;
        rd(FAULT_ADDR, 16'h0011, "fault cause");
        input_phase_loss = 1'b1;
        u_m.xfer(1'b1, OPCMD_ADDR, 16'h0008);
        input_phase_loss = 1'b0;
        rd(FAULT_ADDR, 16'h002E, "event beats reset");
    endtask
    task automatic t_io_analog();
        di_state = 7'h55;
        relay_state = 2'b10;
        pulse_output = 1'b1;
        rd(IO_STATE_ADDR, 16'h6055, "io word");
        ain_one_current = 1'b1;
        ain_one_raw = 16'h04B0;
        rd(AIN_ONE_ADDR, 16'h03E8, "first input clamp");
        ain_two_raw = 16'h0258;
        rd(AIN_TWO_ADDR, 16'h0258, "second input voltage");
        ain_two_current = 1'b1;
        rd(AIN_TWO_ADDR, 16'h01F4, "second input current");
        ain_two_raw = 16'h0064;
        rd(AIN_TWO_ADDR, 16'h0000, "second input below live zero");
        aout_one_raw = -16'sd1500;
        aout_two_raw = 16'sh02BC;
        rd(AOUT_ONE_ADDR, 16'hFC18, "first output clamp");
        rd(AOUT_TWO_ADDR, 16'h02BC, "second output");
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // watchdog: the whole sequence needs about 130 cycles
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        test_done();
    end
    initial begin
        {arst_n, fault_valid, input_phase_loss, pulse_output} = 4'h0;
        {ain_one_current, ain_two_current, di_state, relay_state} = '0;
        {fault_cause, ain_one_raw, ain_two_raw, aout_one_raw, aout_two_raw} = '0;
        drive = '0;
        alarm = '0;
        meas = {16'h1234, 16'h0056, 16'h0DC0, 16'h1518};
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        check("reset commands", cmd_view, 16'h0000);
        check("reset setpoint", freq_setpoint, FREQ_RESET);
        t_command();
        t_setpoint_reserved();
        t_refuse();
        t_status_alarm();
        t_fault();
        t_io_analog();
        test_done();
    end
endmodule // tb_dmr_regmap
